// File: rtl/lcd_irq_and_enable_sequencing.sv
// panel controller interrupt sources, core activation and frame-fetch sequencing
// assumes fetch/fifo/timing conditions arrive unsynchronised; controls are same-clock pulses
`timescale 1ns/1ps
module lcd_irq_and_enable_sequencing
   import lcd_seq_pkg::*;
#(
   parameter logic [GUARD_W-1:0] GUARD_CYCLES = GUARD_DEFAULT
)(
   input  wire logic                    core_clk_i,
   input  wire logic                    rst_i,
   input  wire raw_evt_t                raw_evt_i,
   input  wire irq_wr_t                 irq_wr_i,
   input  wire logic                    power_wr_i,
   input  wire logic                    panel_power_on_i,
   input  wire logic                    fetch_wr_i,
   input  wire logic                    fetch_enable_i,
   input  wire logic                    dual_scan_i,
   input  wire logic                    base_wr_upper_i,
   input  wire logic                    base_wr_lower_i,
   input  wire logic [ADDR_W-1:0]       base_data_i,
   input  wire logic [WORDS_W-1:0]      frame_word_count_i,
   input  wire logic                    word_fetched_i,
   input  wire logic                    word_lower_i,
   input  wire logic [DIV_W-1:0]        pixel_clock_divisor_i,
   input  wire logic                    dither_wr_i,
   input  wire logic [2:0]              dither_sel_i,
   input  wire logic [DITHER_W-1:0]     dither_data_i,
   output logic                         irq_o,
   output logic [NUM_IRQ-1:0]           irq_mask_reg_o,
   output logic [NUM_IRQ-1:0]           irq_status_reg_o,
   output logic                         fetch_run_o,
   output logic                         core_busy_flag_o,
   output logic [ADDR_W-1:0]            upper_addr_o,
   output logic [ADDR_W-1:0]            lower_addr_o,
   output logic [WORDS_W-1:0]           upper_words_left_o,
   output logic [WORDS_W-1:0]           lower_words_left_o,
   output logic                         pixel_clock_out_o,
   output logic [NUM_DITHER*DITHER_W-1:0] dither_pattern_regs_o
);
   import lcd_seq_pkg::*;

   localparam int RAW_W = $bits(raw_evt_t);

   logic [RAW_W-1:0]   sync1_q;
   logic [RAW_W-1:0]   sync2_q;
   raw_evt_t           evt_s;
   logic [NUM_IRQ-1:0] cond;
   logic [NUM_IRQ-1:0] cond_prev_q;
   logic [NUM_IRQ-1:0] evt_pulse;
   logic [NUM_IRQ-1:0] mask_q;
   logic [NUM_IRQ-1:0] status_q;
   logic               eof_pulse;
   logic               frame_done;
   logic               power_q;
   logic               fetch_en_q;
   pwr_state_t         pwr_state_q;
   logic [GUARD_W-1:0] guard_q;
   logic [ADDR_W-1:0]  upper_shadow_q;
   logic [ADDR_W-1:0]  lower_shadow_q;
   logic [DIV_W-1:0]   div_cnt_q;
   logic [DITHER_W-1:0] dither_q [NUM_DITHER];

   // two-flop synchroniser per raw condition
   genvar gi;
   generate
      for (gi = 0; gi < RAW_W; gi++)
      begin : g_sync
         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
            begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end
            else
            begin
               sync1_q[gi] <= raw_evt_i[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   assign evt_s = raw_evt_t'(sync2_q);

   always_comb
   begin
      cond                = IRQ_NONE;
      cond[IRQ_BUS_ERR]   = evt_s.bus_err;
      cond[IRQ_UNDERFLOW] = evt_s.pop_req & evt_s.fifo_empty;
      cond[IRQ_OVERWRITE] = evt_s.push_req & evt_s.fifo_full;
      cond[IRQ_END_LINE]  = evt_s.line_blank & evt_s.fetch_idle;
      cond[IRQ_LAST_LINE] = evt_s.line_blank & evt_s.last_line & evt_s.fetch_idle;
   end

   // levels become one event each on their rising edge
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         cond_prev_q <= IRQ_NONE;
      else
         cond_prev_q <= cond;
   end

   always_comb
   begin
      evt_pulse                = cond & ~cond_prev_q;
      evt_pulse[IRQ_END_FRAME] = eof_pulse;
   end

   // mask: enable sets, disable clears; enable wins if both
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         mask_q <= IRQ_NONE;
      else
         mask_q <= (mask_q & ~irq_wr_i.disable_bits) | irq_wr_i.enable;
   end

   // sticky status; a same-cycle event beats the clear
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         status_q <= IRQ_NONE;
      else
         status_q <= (status_q & ~irq_wr_i.clear) | evt_pulse;
   end

   assign irq_mask_reg_o   = mask_q;
   assign irq_status_reg_o = status_q;

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(((status_q & ~irq_wr_i.clear) | evt_pulse) & mask_q);
   end

   // fetch enable field
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         fetch_en_q <= 1'b0;
      else if (fetch_wr_i)
         fetch_en_q <= fetch_enable_i;
   end

   // core power sequencing; drain keeps busy set for the guard time
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pwr_state_q <= PWR_OFF;
         power_q     <= 1'b0;
         guard_q     <= GUARD_ZERO;
      end
      else
      begin
         case (pwr_state_q)
            PWR_OFF:
               if (power_wr_i && panel_power_on_i)
               begin
                  pwr_state_q <= PWR_ON;
                  power_q     <= 1'b1;
               end
            PWR_ON:
               if (power_wr_i && !panel_power_on_i)
               begin
                  pwr_state_q <= PWR_DRAIN;
                  power_q     <= 1'b0;
                  guard_q     <= GUARD_CYCLES;
               end
            PWR_DRAIN:
               if (guard_q == GUARD_ZERO)
                  pwr_state_q <= PWR_OFF;
               else
                  guard_q <= guard_q - GUARD_ONE;
            default:
               pwr_state_q <= PWR_OFF;
         endcase
      end
   end

   // reactivation during drain is ignored until idle
   assign core_busy_flag_o = (pwr_state_q != PWR_OFF);
   assign fetch_run_o      = power_q & fetch_en_q;

   // frame boundary: all panels in use have run out of words
   assign frame_done = (upper_words_left_o == WORDS_ZERO)
                     && (!dual_scan_i || lower_words_left_o == WORDS_ZERO);
   assign eof_pulse  = fetch_run_o & frame_done;

   // shadow base addresses, written at any time
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         upper_shadow_q <= ADDR_RESET;
         lower_shadow_q <= ADDR_RESET;
      end
      else
      begin
         if (base_wr_upper_i)
            upper_shadow_q <= base_data_i;
         if (base_wr_lower_i)
            lower_shadow_q <= base_data_i;
      end
   end

   // active addresses only change at the frame reload
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         upper_addr_o <= ADDR_RESET;
         lower_addr_o <= ADDR_RESET;
      end
      else if (eof_pulse)
      begin
         upper_addr_o <= upper_shadow_q;
         lower_addr_o <= dual_scan_i ? lower_shadow_q : lower_addr_o;
      end
   end

   // words-left pointers; lower panel idle in single scan
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         upper_words_left_o <= WORDS_ZERO;
         lower_words_left_o <= WORDS_ZERO;
      end
      else if (!fetch_run_o)
      begin
         upper_words_left_o <= WORDS_ZERO;
         lower_words_left_o <= WORDS_ZERO;
      end
      else if (eof_pulse)
      begin
         upper_words_left_o <= frame_word_count_i;
         lower_words_left_o <= dual_scan_i ? frame_word_count_i : WORDS_ZERO;
      end
      else if (word_fetched_i)
      begin
         if (!word_lower_i && upper_words_left_o != WORDS_ZERO)
            upper_words_left_o <= upper_words_left_o - WORDS_ONE;
         if (word_lower_i && dual_scan_i && lower_words_left_o != WORDS_ZERO)
            lower_words_left_o <= lower_words_left_o - WORDS_ONE;
      end
   end

   // pixel clock toggles every divisor+1 core cycles
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         div_cnt_q         <= DIV_ZERO;
         pixel_clock_out_o <= 1'b0;
      end
      else if (!power_q)
      begin
         div_cnt_q         <= DIV_ZERO;
         pixel_clock_out_o <= 1'b0;
      end
      else if (div_cnt_q >= pixel_clock_divisor_i)
      begin
         div_cnt_q         <= DIV_ZERO;
         pixel_clock_out_o <= ~pixel_clock_out_o;
      end
      else
         div_cnt_q <= div_cnt_q + DIV_ONE;
   end

   // dither patterns; recommended values present without software
   generate
      for (gi = 0; gi < NUM_DITHER; gi++)
      begin : g_dither
         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
               dither_q[gi] <= DITHER_RESET[gi];
            else if (dither_wr_i && dither_sel_i == 3'(gi))
               dither_q[gi] <= dither_data_i;
         end
         assign dither_pattern_regs_o[gi*DITHER_W +: DITHER_W] = dither_q[gi];
      end
   endgenerate

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_STATUS_STICKY: assert property (
      (status_q != IRQ_NONE) && (irq_wr_i.clear == IRQ_NONE)
      |=> (status_q & $past(status_q)) == $past(status_q))
      else $error("status bit dropped without a clear");
   AST_EVT_RECORDED: assert property (
      (evt_pulse != IRQ_NONE) |=> (status_q & $past(evt_pulse)) == $past(evt_pulse))
      else $error("event not recorded in status");
   AST_BUSERR_PATH: assert property (
      $rose(raw_evt_i.bus_err) ##1 raw_evt_i.bus_err[*2] |=> status_q[IRQ_BUS_ERR])
      else $error("bus error not recorded after synchroniser delay");
   AST_IRQ_MASKED: assert property (
      (evt_pulse & mask_q) != IRQ_NONE |=> irq_o)
      else $error("masked pending event did not raise irq");
   AST_IRQ_QUIET: assert property (
      (mask_q == IRQ_NONE) ##1 (mask_q == IRQ_NONE) |-> !irq_o)
      else $error("irq with all sources masked");
   AST_MASK_ZERO_KEEP: assert property (
      (irq_wr_i.enable == IRQ_NONE) && (irq_wr_i.disable_bits == IRQ_NONE)
      |=> mask_q == $past(mask_q))
      else $error("mask changed without a write");
   AST_MASK_DISABLE: assert property (
      irq_wr_i.disable_bits[IRQ_END_LINE] && !irq_wr_i.enable[IRQ_END_LINE]
      |=> !mask_q[IRQ_END_LINE])
      else $error("disable did not clear mask bit");
   AST_RUN_NEEDS_POWER: assert property (
      fetch_run_o |-> power_q && fetch_en_q && core_busy_flag_o)
      else $error("fetch running without power or enable");
   AST_RELOAD_BASE: assert property (
      eof_pulse |=> upper_addr_o == $past(upper_shadow_q)
                 && upper_words_left_o == $past(frame_word_count_i))
      else $error("frame reload did not take shadow base");
   AST_BASE_HOLD: assert property (
      !eof_pulse |=> upper_addr_o == $past(upper_addr_o))
      else $error("base address changed mid frame");
   AST_PTR_DOWN: assert property (
      fetch_run_o && !eof_pulse && word_fetched_i && !word_lower_i
      && upper_words_left_o != WORDS_ZERO
      |=> upper_words_left_o == $past(upper_words_left_o) - WORDS_ONE)
      else $error("words-left pointer did not count down");
   AST_PIX_DIV: assert property (
      power_q && $past(power_q) && $changed(pixel_clock_out_o)
      |-> $past(div_cnt_q) >= $past(pixel_clock_divisor_i))
      else $error("pixel clock toggled before divisor reached");
   AST_BUSY_DRAIN: assert property (
      $fell(power_q) |-> core_busy_flag_o)
      else $error("busy dropped at power off");

   COV_EOF: cover property (eof_pulse ##[1:300] eof_pulse);
   COV_IRQ_CLEAR: cover property (irq_o ##1 (irq_wr_i.clear != IRQ_NONE) ##1 !irq_o);
   COV_SET_CLEAR_RACE: cover property ((evt_pulse & irq_wr_i.clear) != IRQ_NONE);
   COV_SHUTDOWN: cover property ($fell(power_q) ##[1:300] !core_busy_flag_o);
endmodule

// File: rtl/lcd_seq_pkg.sv
// shared constants and carriers for the panel controller irq and sequencing block
// assumes a single core clock domain; no register bus, all controls are ports
package lcd_seq_pkg;
   localparam int          NUM_IRQ        = 6;
   localparam int          IRQ_BUS_ERR    = 0;
   localparam int          IRQ_UNDERFLOW  = 1;
   localparam int          IRQ_OVERWRITE  = 2;
   localparam int          IRQ_END_FRAME  = 3;
   localparam int          IRQ_END_LINE   = 4;
   localparam int          IRQ_LAST_LINE  = 5;
   localparam int          ADDR_W         = 32;
   localparam int          WORDS_W        = 23;
   localparam int          DIV_W          = 9;
   localparam int          DITHER_W       = 28;
   localparam int          NUM_DITHER     = 8;
   localparam int          GUARD_W        = 8;
   localparam logic [GUARD_W-1:0] GUARD_DEFAULT = 8'h0E;
   // recommended dither patterns loaded at reset
   localparam logic [DITHER_W-1:0] DITHER_RESET [NUM_DITHER] = '{
      28'h00000A5, 28'h5AF0FA5, 28'h00A5A5F, 28'h0000A5F,
      28'hFAF5FA5, 28'h000FAF5, 28'h00FAF5F, 28'hF5FFAFF};
   localparam logic [ADDR_W-1:0]  ADDR_RESET  = 32'h00000000;
   localparam logic [WORDS_W-1:0] WORDS_ZERO  = 23'h000000;
   localparam logic [WORDS_W-1:0] WORDS_ONE   = 23'h000001;
   localparam logic [DIV_W-1:0]   DIV_ZERO    = 9'h000;
   localparam logic [DIV_W-1:0]   DIV_ONE     = 9'h001;
   localparam logic [GUARD_W-1:0] GUARD_ZERO  = 8'h00;
   localparam logic [GUARD_W-1:0] GUARD_ONE   = 8'h01;
   localparam logic [NUM_IRQ-1:0] IRQ_NONE    = 6'h00;

   // raw conditions arriving from the fetch, fifo and timing logic
   typedef struct packed {
      logic bus_err;
      logic pop_req;
      logic fifo_empty;
      logic push_req;
      logic fifo_full;
      logic line_blank;
      logic last_line;
      logic fetch_idle;
   } raw_evt_t;

   typedef struct packed {
      logic [NUM_IRQ-1:0] enable;
      logic [NUM_IRQ-1:0] disable_bits;
      logic [NUM_IRQ-1:0] clear;
   } irq_wr_t;

   typedef enum logic [1:0] {
      PWR_OFF,
      PWR_ON,
      PWR_DRAIN
   } pwr_state_t;
endpackage

// File: dv/lcd_panel_model.sv
// far-side model: fetches words for the active panels at a pace set by the bench
// assumes go and gap come from the bench; reports the measured pixel clock period
`timescale 1ns/1ps
module lcd_panel_model
   import lcd_seq_pkg::*;
(
   input  wire logic               clk_i,
   input  wire logic               go_i,
   input  wire logic [3:0]         gap_i,
   input  wire logic               run_i,
   input  wire logic               dual_i,
   input  wire logic [WORDS_W-1:0] upper_left_i,
   input  wire logic [WORDS_W-1:0] lower_left_i,
   input  wire logic               pix_i,
   output logic                    word_o,
   output logic                    lower_o,
   output int                      period_o
);
   int   wait_q = 0;
   int   cnt_q = 0;
   logic pix_q = 1'b0;
   logic up_w;
   logic lo_w;
   initial
   begin
      word_o = 1'b0;
      lower_o = 1'b0;
      period_o = 0;
   end
   assign up_w = upper_left_i != WORDS_ZERO;
   assign lo_w = dual_i && lower_left_i != WORDS_ZERO;
   // the gap sets the pace; the bench ties it to 6, so only slow fetching is seen
   always @(negedge clk_i)
   begin
      if (!go_i || !run_i || !(up_w || lo_w))
      begin
         wait_q <= 0;
         word_o <= 1'b0;
      end
      else if (wait_q < gap_i)
      begin
         wait_q <= wait_q + 1;
         word_o <= 1'b0;
      end
      else
      begin
         wait_q <= 0;
         word_o <= 1'b1;
         lower_o <= lo_w && (!up_w || !lower_o);
      end
   end
   always @(posedge clk_i)
   begin
      pix_q <= pix_i;
      cnt_q <= (pix_i && !pix_q) ? 1 : cnt_q + 1;
      if (pix_i && !pix_q)
         period_o <= cnt_q;
   end
endmodule

// File: dv/tb_lcd_irq_and_enable_sequencing.sv
// self-checking bench for the irq and fetch sequencing block
// assumes the panel fetch model beside it; inputs change at the falling edge
`timescale 1ns/1ps
module tb_lcd_irq_and_enable_sequencing;
   import lcd_seq_pkg::*;
   // short drain keeps the run brief
   localparam logic [GUARD_W-1:0] GUARD = 8'h02;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   raw_evt_t              raw = '0;
   irq_wr_t               wr = '0;
   logic                  pw = 1'b0, pon = 1'b0, fw = 1'b0, fen = 1'b0, dual = 1'b0;
   logic                  bwu = 1'b0, bwl = 1'b0, dw = 1'b0, go = 1'b0;
   logic [ADDR_W-1:0]     bd = '0, ua, la, a1, a2;
   logic [WORDS_W-1:0]    fwc = 23'h000004, ul, ll;
   logic [DIV_W-1:0]      dv = '0;
   logic [2:0]            ds = 3'h0;
   logic [DITHER_W-1:0]   dd = '0;
   logic [NUM_IRQ-1:0]    msk, st, em;
   logic [NUM_DITHER*DITHER_W-1:0] dp;
   logic                  irq, run, busy, pix, wf, wl;
   logic [31:0]           lfsr = 32'h6E91B837;
   int                    per, i;
   int                    cyc = 0;
   int                    checked = 0;
   int                    n_mismatch = 0;
   logic [7:0]            ev_raw [7] = '{8'h80, 8'h60, 8'h18, 8'h05, 8'h07, 8'h40, 8'h06};
   logic [5:0]            ev_exp [7] = '{6'h01, 6'h02, 6'h04, 6'h10, 6'h30, 6'h00, 6'h00};

   always #2.5 clk = ~clk;

   lcd_irq_and_enable_sequencing #(.GUARD_CYCLES(GUARD)) DUT (
      .core_clk_i(clk), .rst_i(rst), .raw_evt_i(raw), .irq_wr_i(wr),
      .power_wr_i(pw), .panel_power_on_i(pon), .fetch_wr_i(fw), .fetch_enable_i(fen),
      .dual_scan_i(dual), .base_wr_upper_i(bwu), .base_wr_lower_i(bwl),
      .base_data_i(bd), .frame_word_count_i(fwc), .word_fetched_i(wf),
      .word_lower_i(wl), .pixel_clock_divisor_i(dv), .dither_wr_i(dw),
      .dither_sel_i(ds), .dither_data_i(dd), .irq_o(irq), .irq_mask_reg_o(msk),
      .irq_status_reg_o(st), .fetch_run_o(run), .core_busy_flag_o(busy),
      .upper_addr_o(ua), .lower_addr_o(la), .upper_words_left_o(ul),
      .lower_words_left_o(ll), .pixel_clock_out_o(pix), .dither_pattern_regs_o(dp));

   lcd_panel_model panel (
      .clk_i(clk), .go_i(go), .gap_i(4'h6), .run_i(run), .dual_i(dual),
      .upper_left_i(ul), .lower_left_i(ll), .pix_i(pix),
      .word_o(wf), .lower_o(wl), .period_o(per));

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   // enable wins over disable on the same bit
   function automatic logic [5:0] exp_mask(input logic [5:0] old, input logic [5:0] en,
                                           input logic [5:0] dis);
      return (old & ~dis) | en;
   endfunction

   task automatic chk_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic strobe(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask

   task automatic pulse_wr(input logic [5:0] en, input logic [5:0] dis, input logic [5:0] clr);
      wr = '{en, dis, clr};
      @(negedge clk);
      wr = '0;
      @(negedge clk);
   endtask

   // bounded poll; returns at the falling edge where the frame flag is first seen
   task automatic wait_eof();
      for (int n = 0; n < 300 && st[IRQ_END_FRAME] !== 1'b1; n++)
         @(negedge clk);
      chk_bit("end of frame", 1'b1, st[IRQ_END_FRAME]);
   endtask

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // whole run needs under a thousand cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end

   initial
   begin
      tick(12);
      rst = 1'b0;
      for (i = 0; i < NUM_DITHER; i++)
         chk_vec("dither reset", 32'(DITHER_RESET[i]), 32'(dp[i*DITHER_W +: DITHER_W]));
      chk_vec("status reset", '0, st);
      ds = 3'(rnd());
      dd = 28'(rnd());
      strobe(dw);
      chk_vec("dither write", 32'(dd), 32'(dp[ds*DITHER_W +: DITHER_W]));
      $display("reset and dither test done");
      em = '0;
      for (i = 0; i < 12; i++)
      begin
         a1 = rnd();
         if (i < 2)
            a1[11:0] = (i == 0) ? 12'hFFF : 12'hFC0;
         em = exp_mask(em, a1[5:0], a1[11:6]);
         pulse_wr(a1[5:0], a1[11:6], '0);
         chk_vec("irq mask", 32'(em), 32'(msk));
      end
      $display("mask test done");
      for (i = 0; i < 7; i++)
      begin
         raw = ev_raw[i];
         tick(2);
         chk_vec("status early", '0, 32'(st));
         tick(3);
         chk_vec("status", 32'(ev_exp[i]), 32'(st));
         chk_bit("irq", |(ev_exp[i] & em), irq);
         raw = '0;
         tick(5);
         chk_vec("status held", 32'(ev_exp[i]), 32'(st));
         pulse_wr('0, '0, 6'h3F);
         chk_vec("status cleared", '0, 32'(st));
         chk_bit("irq cleared", 1'b0, irq);
      end
      // clear lands on the very edge the event is recorded; the event must win
      raw = ev_raw[0];
      tick(2);
      pulse_wr('0, '0, 6'h3F);
      chk_vec("status race", 32'(ev_exp[0]), 32'(st));
      raw = '0;
      tick(5);
      pulse_wr('0, '0, 6'h3F);
      chk_vec("status race cleared", '0, 32'(st));
      $display("event test done");
      // divisor is the only timing field driven; the rest stay zero
      dv = 9'(rnd() & 32'h3);
      a1 = rnd() & 32'hFFFFFFFC;
      bd = a1;
      strobe(bwu);
      bd = rnd();
      strobe(bwl);
      chk_vec("upper addr idle", '0, ua);
      fen = 1'b1;
      strobe(fw);
      chk_bit("run before power", 1'b0, run);
      pon = 1'b1;
      strobe(pw);
      wait_eof();
      chk_bit("run", 1'b1, run);
      chk_bit("busy on", 1'b1, busy);
      chk_vec("upper addr", a1, ua);
      chk_vec("lower addr single", '0, la);
      chk_vec("upper left", 32'd4, 32'(ul));
      pulse_wr('0, '0, 6'h08);
      a2 = rnd() & 32'hFFFFFFFC;
      bd = a2;
      strobe(bwu);
      chk_vec("upper addr mid frame", a1, ua);
      go = 1'b1;
      for (i = 0; i < 40 && ul == 23'd4; i++)
         @(negedge clk);
      chk_vec("upper left step", 32'd3, 32'(ul));
      wait_eof();
      chk_vec("upper addr swapped", a2, ua);
      chk_vec("pixel period", 32'(2 * (int'(dv) + 1)), 32'(per));
      pulse_wr('0, '0, 6'h08);
      dual = 1'b1;
      a1 = rnd() & 32'hFFFFFFFC;
      bd = a1;
      strobe(bwu);
      a2 = rnd() & 32'hFFFFFFFC;
      bd = a2;
      strobe(bwl);
      wait_eof();
      chk_vec("dual upper", a1, ua);
      chk_vec("dual lower", a2, la);
      chk_vec("lower left", 32'd4, 32'(ll));
      pulse_wr('0, '0, 6'h08);
      wait_eof();
      chk_vec("lower left reload", 32'd4, 32'(ll));
      $display("frame test done");
      go = 1'b0;
      pon = 1'b0;
      strobe(pw);
      chk_bit("busy draining", 1'b1, busy);
      pon = 1'b1;
      strobe(pw);
      tick(GUARD + 2);
      chk_bit("busy idle", 1'b0, busy);
      chk_bit("run after off", 1'b0, run);
      chk_vec("left cleared", '0, 32'(ul));
      chk_bit("pixel clock off", 1'b0, pix);
      fen = 1'b0;
      strobe(fw);
      chk_bit("run disabled", 1'b0, run);
      $display("shutdown test done");
      wrap_up();
   end
endmodule
